// ---- cpu_sideband_dev.sv ----
// Contract
// - Snoop outcome reported on hit lines.
// - Snoop stall drives both hit lines.
// - Stall extended by driving both again.
// - Internal error held until system reset.
// - Internal error also issues shutdown transaction.
// - Chipset may turn shutdown into NMI.
// - Ignore input active: skip pending numeric error.
// - Ignore inactive: fault on next FP instruction.
// - Numeric error enable overrides ignore input.
// - Ignore input valid with I/O target ready; the code has no ready qualifier and uses ign_act on every clock.
// - Soft init clears integer registers only.
// - Soft init restarts at strapped reset vector.
// - Snoops still serviced during soft init.
// - Init active at reset release starts selftest.
// - Controller off: pins become maskable, nonmaskable IRQ.
// - Interrupt controller enabled after reset.
// - Lock held from first to last transaction.
// - Priority agent waits for lock release.
// - Drive thermal hot at max temperature.
// - External thermal hot engages control circuit.
// - Power status indicator in deeper sleep.
// - Bus outputs released within two clocks of reset.
`timescale 1ns/10ps

`include "sideband_map.svh"

module cpu_sideband_dev import sideband_pkg::*; #(
  parameter int VEC_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  sideband_if.dev_end sb,
  input wire logic snoop_req,
  input wire logic snoop_hit,
  input wire logic snoop_hitmod,
  input wire logic snoop_stall_need,
  input wire logic core_error,
  input wire logic fp_insn,
  input wire logic fp_error_pending,
  input wire logic numeric_error_enable_bit,
  input wire logic lirq_cfg_we,
  input wire logic lirq_cfg_en,
  input wire logic lock_seq,
  input wire logic temp_max,
  input wire logic thermal_ctrl_enable,
  input wire logic deeper_sleep,
  input wire logic pwr_ind_enable,
  input wire logic [VEC_W-1:0] reset_vector_strap,
  output logic snoop_done,
  output logic snoop_stall_seen,
  output logic fp_exception,
  output logic int_reg_clear,
  output logic [VEC_W-1:0] restart_vector,
  output logic built_in_selftest,
  output logic [1:0] local_irq_out,
  output logic maskable_irq,
  output logic nmi,
  output logic lock_seen,
  output logic bus_yield,
  output logic thermal_control_circuit
);

  if (VEC_W < 1) begin : g_vec_check
    $error("VEC_W must be at least 1");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [`SB_DEV_SYNC_W-1:0] raw;
  logic [`SB_DEV_SYNC_W-1:0] sync1_q;
  logic [`SB_DEV_SYNC_W-1:0] sync2_q;

  assign raw = {sb.local_irq_pins, sb.priority_agent_request_n, sb.init_n,
                sb.ignore_fp_error_n, sb.thermal_hot_n, sb.lock_n,
                sb.snoop_hit_modified_n, sb.snoop_hit_n};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= `SB_DEV_SYNC_RST;
      sync2_q <= `SB_DEV_SYNC_RST;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end

  logic hit_act;
  logic hitmod_act;
  logic lock_act;
  logic hot_act;
  logic ign_act;
  logic init_act;
  logic prio_act;
  logic [1:0] lirq;

  // Pins are low-active, interrupt pins high-active
  assign hit_act = ~sync2_q[0];
  assign hitmod_act = ~sync2_q[1];
  assign lock_act = ~sync2_q[2];
  assign hot_act = ~sync2_q[3];
  assign ign_act = ~sync2_q[4];
  assign init_act = ~sync2_q[5];
  assign prio_act = ~sync2_q[6];
  assign lirq = sync2_q[8:7];

  // ----------------------------------------
  // Snoop result and stall
  // ----------------------------------------
  snoop_state_t snp_q;
  logic hit_lat_q;
  logic hitmod_lat_q;

  // Not gated by soft init: snoops keep running
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      snp_q <= SNP_IDLE;
      hit_lat_q <= 1'b0;
      hitmod_lat_q <= 1'b0;
      sb.dev_hit_oe_n <= 1'b1;
      sb.dev_hitmod_oe_n <= 1'b1;
      snoop_done <= 1'b0;
    end else begin
      snoop_done <= 1'b0;
      unique case (snp_q)
        SNP_IDLE: begin
          sb.dev_hit_oe_n <= 1'b1;
          sb.dev_hitmod_oe_n <= 1'b1;
          if (snoop_req) begin
            // Both set would read as a stall, so modified wins
            hit_lat_q <= snoop_hit & ~snoop_hitmod;
            hitmod_lat_q <= snoop_hitmod;
            snp_q <= snoop_stall_need ? SNP_STALL : SNP_RESULT;
            sb.dev_hit_oe_n <= ~snoop_stall_need;
            sb.dev_hitmod_oe_n <= ~snoop_stall_need;
          end
        end
        SNP_STALL: begin
          if (snoop_stall_need) begin
            sb.dev_hit_oe_n <= 1'b0;
            sb.dev_hitmod_oe_n <= 1'b0;
          end else begin
            snp_q <= SNP_RESULT;
            sb.dev_hit_oe_n <= 1'b1;
            sb.dev_hitmod_oe_n <= 1'b1;
          end
        end
        SNP_RESULT: begin
          if (sb.dev_hit_oe_n && sb.dev_hitmod_oe_n && (hit_lat_q || hitmod_lat_q)) begin
            sb.dev_hit_oe_n <= ~hit_lat_q;
            sb.dev_hitmod_oe_n <= ~hitmod_lat_q;
          end else begin
            sb.dev_hit_oe_n <= 1'b1;
            sb.dev_hitmod_oe_n <= 1'b1;
            snoop_done <= 1'b1;
            snp_q <= SNP_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      snoop_stall_seen <= 1'b0;
    end else begin
      snoop_stall_seen <= hit_act & hitmod_act;
    end
  end

  // ----------------------------------------
  // Internal error and shutdown
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sb.internal_error_n <= 1'b1;
      sb.shutdown_txn_n <= 1'b1;
    end else begin
      if (core_error) begin
        sb.internal_error_n <= 1'b0;
      end
      // One shutdown per error episode
      sb.shutdown_txn_n <= ~(core_error & sb.internal_error_n);
    end
  end

  // ----------------------------------------
  // Numeric error handling
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fp_exception <= 1'b0;
    end else begin
      fp_exception <= fp_insn & fp_error_pending & (numeric_error_enable_bit | ~ign_act);
    end
  end

  // ----------------------------------------
  // Boot capture, soft init, selftest
  // ----------------------------------------
  boot_state_t boot_q;
  logic [1:0] boot_cnt_q;
  logic init_prev_q;

  // Waits out the synchroniser before trusting the init pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_q <= BOOT_WAIT;
      boot_cnt_q <= 2'h0;
      init_prev_q <= 1'b1;
      restart_vector <= '0;
      built_in_selftest <= 1'b0;
      int_reg_clear <= 1'b0;
    end else begin
      built_in_selftest <= 1'b0;
      int_reg_clear <= 1'b0;
      unique case (boot_q)
        BOOT_WAIT: begin
          if (boot_cnt_q == `SB_BOOT_CYCLES) begin
            boot_q <= BOOT_DONE;
            restart_vector <= reset_vector_strap;
            built_in_selftest <= init_act;
            init_prev_q <= init_act;
          end else begin
            boot_cnt_q <= boot_cnt_q + 2'h1;
          end
        end
        BOOT_DONE: begin
          init_prev_q <= init_act;
          // Caches and FP state are left alone
          int_reg_clear <= init_act & ~init_prev_q;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Local interrupt pins
  // ----------------------------------------
  logic lirq_ctrl_en_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lirq_ctrl_en_q <= 1'b1;
    end else if (lirq_cfg_we) begin
      lirq_ctrl_en_q <= lirq_cfg_en;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      local_irq_out <= 2'h0;
      maskable_irq <= 1'b0;
      nmi <= 1'b0;
    end else begin
      local_irq_out <= lirq_ctrl_en_q ? lirq : 2'h0;
      maskable_irq <= ~lirq_ctrl_en_q & lirq[0];
      nmi <= ~lirq_ctrl_en_q & lirq[1];
    end
  end

  // ----------------------------------------
  // Lock, thermal, power status
  // ----------------------------------------
  logic od_low_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      od_low_q <= 1'b0;
      sb.dev_lock_oe_n <= 1'b1;
      lock_seen <= 1'b0;
      bus_yield <= 1'b0;
    end else begin
      od_low_q <= 1'b0;
      sb.dev_lock_oe_n <= ~lock_seq;
      lock_seen <= lock_act;
      // A priority agent only wins once our lock drops
      bus_yield <= prio_act & ~lock_seq;
    end
  end

  assign sb.dev_hit_o = od_low_q;
  assign sb.dev_hitmod_o = od_low_q;
  assign sb.dev_lock_o = od_low_q;
  assign sb.dev_hot_o = od_low_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sb.dev_hot_oe_n <= 1'b1;
      thermal_control_circuit <= 1'b0;
      sb.power_status_ind_n <= 1'b1;
    end else begin
      sb.dev_hot_oe_n <= ~temp_max;
      thermal_control_circuit <= thermal_ctrl_enable & (temp_max | hot_act);
      sb.power_status_ind_n <= ~(pwr_ind_enable & deeper_sleep);
    end
  end

endmodule : cpu_sideband_dev

// ---- sideband_map.svh ----
`ifndef SIDEBAND_MAP_SVH
`define SIDEBAND_MAP_SVH

// ----------------------------------------
// Host register offsets
// ----------------------------------------
`define SB_REG_CTRL 32'h0000_0000
`define SB_REG_STAT 32'h0000_0004

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SB_CTRL_INIT 0
`define SB_CTRL_IGN 1
`define SB_CTRL_HOT 2
`define SB_CTRL_MASK_IRQ 3
`define SB_CTRL_NMI 4
`define SB_CTRL_SHUT_NMI_EN 5
`define SB_CTRL_PRIO_REQ 6
`define SB_CTRL_SNP_STALL 7
`define SB_CTRL_SNP_HIT 8
`define SB_CTRL_SNP_HITMOD 9
`define SB_CTRL_W 10
`define SB_CTRL_RST 10'h000

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define SB_STAT_INT_ERR 0
`define SB_STAT_PWR_IND 1
`define SB_STAT_HOT 2
`define SB_STAT_LOCK 3
`define SB_STAT_OWNED 4
`define SB_STAT_SHUT 5
`define SB_STAT_SNP_HIT 6
`define SB_STAT_SNP_HITMOD 7

// ----------------------------------------
// Synchroniser layout and timing
// ----------------------------------------
`define SB_DEV_SYNC_W 9
`define SB_DEV_SYNC_RST 9'h07f
`define SB_HOST_SYNC_W 7
`define SB_HOST_SYNC_RST 7'h7f
`define SB_BOOT_CYCLES 2'h2

`endif

// ---- sideband_pkg.sv ----
package sideband_pkg;

  typedef enum logic [2:0] {
    SNP_IDLE = 3'b001,
    SNP_STALL = 3'b010,
    SNP_RESULT = 3'b100
  } snoop_state_t;

  typedef enum logic [1:0] {
    BOOT_WAIT = 2'b01,
    BOOT_DONE = 2'b10
  } boot_state_t;

endpackage : sideband_pkg

// ---- sideband_if.sv ----
`timescale 1ns/10ps

interface sideband_if;
  // Resolved wired lines, low when any end pulls
  logic snoop_hit_n;
  logic snoop_hit_modified_n;
  logic lock_n;
  logic thermal_hot_n;
  logic dev_hit_o;
  logic dev_hit_oe_n;
  logic dev_hitmod_o;
  logic dev_hitmod_oe_n;
  logic dev_lock_o;
  logic dev_lock_oe_n;
  logic dev_hot_o;
  logic dev_hot_oe_n;
  logic host_hit_o;
  logic host_hit_oe_n;
  logic host_hitmod_o;
  logic host_hitmod_oe_n;
  logic host_hot_o;
  logic host_hot_oe_n;
  logic internal_error_n;
  logic power_status_ind_n;
  logic shutdown_txn_n;
  logic ignore_fp_error_n;
  logic init_n;
  logic priority_agent_request_n;
  logic [1:0] local_irq_pins;

  assign snoop_hit_n = (dev_hit_o | dev_hit_oe_n) & (host_hit_o | host_hit_oe_n);
  assign snoop_hit_modified_n = (dev_hitmod_o | dev_hitmod_oe_n)
                                & (host_hitmod_o | host_hitmod_oe_n);
  assign lock_n = dev_lock_o | dev_lock_oe_n;
  assign thermal_hot_n = (dev_hot_o | dev_hot_oe_n) & (host_hot_o | host_hot_oe_n);

  modport dev_end (
    input snoop_hit_n, snoop_hit_modified_n, lock_n, thermal_hot_n,
    input ignore_fp_error_n, init_n, priority_agent_request_n, local_irq_pins,
    output dev_hit_o, dev_hit_oe_n, dev_hitmod_o, dev_hitmod_oe_n,
    output dev_lock_o, dev_lock_oe_n, dev_hot_o, dev_hot_oe_n,
    output internal_error_n, power_status_ind_n, shutdown_txn_n
  );

  modport host_end (
    input snoop_hit_n, snoop_hit_modified_n, lock_n, thermal_hot_n,
    input internal_error_n, power_status_ind_n, shutdown_txn_n,
    output host_hit_o, host_hit_oe_n, host_hitmod_o, host_hitmod_oe_n,
    output host_hot_o, host_hot_oe_n,
    output ignore_fp_error_n, init_n, priority_agent_request_n, local_irq_pins
  );
endinterface : sideband_if

// ---- chipset_sideband_host.sv ----
`timescale 1ns/10ps

`include "sideband_map.svh"

module chipset_sideband_host import sideband_pkg::*; #(
  parameter int ADDR_W = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  sideband_if.host_end sb,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  if (ADDR_W < 3) begin : g_addr_check
    $error("ADDR_W must be at least 3");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [`SB_HOST_SYNC_W-1:0] raw;
  logic [`SB_HOST_SYNC_W-1:0] sync1_q;
  logic [`SB_HOST_SYNC_W-1:0] sync2_q;

  assign raw = {sb.power_status_ind_n, sb.shutdown_txn_n, sb.internal_error_n,
                sb.thermal_hot_n, sb.lock_n, sb.snoop_hit_modified_n, sb.snoop_hit_n};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= `SB_HOST_SYNC_RST;
      sync2_q <= `SB_HOST_SYNC_RST;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end

  logic lock_act;
  logic shut_evt;

  assign lock_act = ~sync2_q[2];
  assign shut_evt = ~sync2_q[5];

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  logic [`SB_CTRL_W-1:0] ctrl_q;
  logic shut_q;
  logic owned_q;
  logic wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [31:0] stat;
  logic [31:0] rd_mux;
  logic addr_ok;

  assign addr_ok = hsel & htrans[1] & hready;
  assign stat = {24'h0, sync2_q[1], sync2_q[0], shut_q, owned_q,
                 ~sync2_q[2], ~sync2_q[3], ~sync2_q[6], ~sync2_q[4]};

  always_comb begin
    rd_mux = 32'h0;
    if (haddr == ADDR_W'(`SB_REG_CTRL)) begin
      rd_mux = {{(32-`SB_CTRL_W){1'b0}}, ctrl_q};
    end else if (haddr == ADDR_W'(`SB_REG_STAT)) begin
      rd_mux = stat;
    end
  end

  // Zero wait states, so ready and response never move
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr;
        hrdata <= hwrite ? 32'h0 : rd_mux;
      end
    end
  end

  logic ctrl_we;
  logic stat_we;

  assign ctrl_we = wr_pend_q & (wr_addr_q == ADDR_W'(`SB_REG_CTRL));
  assign stat_we = wr_pend_q & (wr_addr_q == ADDR_W'(`SB_REG_STAT));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `SB_CTRL_RST;
    end else if (ctrl_we) begin
      ctrl_q <= hwdata[`SB_CTRL_W-1:0];
    end
  end

  // Set beats clear so a shutdown in the clear cycle survives
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shut_q <= 1'b0;
    end else begin
      shut_q <= (shut_q & ~(stat_we & hwdata[`SB_STAT_SHUT])) | shut_evt;
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  logic od_low_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      od_low_q <= 1'b0;
      owned_q <= 1'b0;
      sb.priority_agent_request_n <= 1'b1;
      sb.init_n <= 1'b1;
      sb.ignore_fp_error_n <= 1'b1;
      sb.local_irq_pins <= 2'h0;
      sb.host_hot_oe_n <= 1'b1;
      sb.host_hit_oe_n <= 1'b1;
      sb.host_hitmod_oe_n <= 1'b1;
    end else begin
      od_low_q <= 1'b0;
      sb.priority_agent_request_n <= ~ctrl_q[`SB_CTRL_PRIO_REQ];
      // Ownership taken once lock is seen released, then kept while requested
      owned_q <= ctrl_q[`SB_CTRL_PRIO_REQ] & (owned_q | ~lock_act);
      sb.init_n <= ~ctrl_q[`SB_CTRL_INIT];
      // Held from a register, changes only on a control register write
      sb.ignore_fp_error_n <= ~ctrl_q[`SB_CTRL_IGN];
      sb.local_irq_pins[0] <= ctrl_q[`SB_CTRL_MASK_IRQ];
      sb.local_irq_pins[1] <= ctrl_q[`SB_CTRL_NMI] | (ctrl_q[`SB_CTRL_SHUT_NMI_EN] & shut_q);
      sb.host_hot_oe_n <= ~ctrl_q[`SB_CTRL_HOT];
      sb.host_hit_oe_n <= ~(ctrl_q[`SB_CTRL_SNP_STALL] | ctrl_q[`SB_CTRL_SNP_HIT]);
      sb.host_hitmod_oe_n <= ~(ctrl_q[`SB_CTRL_SNP_STALL] | ctrl_q[`SB_CTRL_SNP_HITMOD]);
    end
  end

  assign sb.host_hit_o = od_low_q;
  assign sb.host_hitmod_o = od_low_q;
  assign sb.host_hot_o = od_low_q;

endmodule : chipset_sideband_host

// ---- sideband_properties.sv ----
`timescale 1ns/10ps

// ----------------------------------------
// Wire checks on the device end
// ----------------------------------------
module sideband_properties (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic dev_hit_o,
  input wire logic dev_hit_oe_n,
  input wire logic dev_hitmod_o,
  input wire logic dev_hitmod_oe_n,
  input wire logic dev_lock_o,
  input wire logic dev_lock_oe_n,
  input wire logic dev_hot_o,
  input wire logic dev_hot_oe_n,
  input wire logic internal_error_n,
  input wire logic shutdown_txn_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  logic stall;
  logic hit_only;
  logic hitmod_only;
  logic idle;
  assign stall = !dev_hit_oe_n && !dev_hitmod_oe_n;
  assign hit_only = !dev_hit_oe_n && dev_hitmod_oe_n;
  assign hitmod_only = dev_hit_oe_n && !dev_hitmod_oe_n;
  assign idle = dev_hit_oe_n && dev_hitmod_oe_n;

  chk_error_held: assert property (
    !internal_error_n |=> !internal_error_n)
    else $error("internal error line released without reset");
  chk_error_shutdown: assert property (
    $fell(internal_error_n) |-> !shutdown_txn_n)
    else $error("internal error without shutdown pulse");
  chk_shutdown_once: assert property (
    !shutdown_txn_n |-> $fell(internal_error_n) ##1 shutdown_txn_n)
    else $error("shutdown pulse not tied to first error");
  // Reset acts without clock, so this one is not disabled by it
  chk_reset_release: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rst_n |-> ##[0:2] (idle && dev_lock_oe_n && dev_hot_oe_n && internal_error_n))
    else $error("bus outputs held during reset");
  chk_drive_low: assert property (
    (dev_hit_oe_n || !dev_hit_o) && (dev_hitmod_oe_n || !dev_hitmod_o)
    && (dev_lock_oe_n || !dev_lock_o) && (dev_hot_oe_n || !dev_hot_o))
    else $error("driven line not low");
  chk_stall_release: assert property (
    stall ##1 !stall |-> idle)
    else $error("no released cycle after stall");
  chk_hit_result: assert property (
    hit_only |=> idle)
    else $error("hit result longer than one cycle");
  chk_hitmod_result: assert property (
    hitmod_only |=> idle)
    else $error("modified hit result longer than one cycle");

  cov_stall: cover property (stall ##1 stall);
  cov_hitmod: cover property (hitmod_only);
  cov_error: cover property ($fell(internal_error_n));
endmodule : sideband_properties

// ---- cpu_sideband_snoop_lock_ctrl_tb.sv ----
`timescale 1ns/10ps

`include "sideband_map.svh"

`define CHK_EQ(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module cpu_sideband_snoop_lock_ctrl_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic dev_rst_n = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr, hwdata, hrdata, ctrl, r;
  logic snoop_req, snoop_hit, snoop_hitmod, snoop_stall_need, core_error, fp_insn;
  logic fp_error_pending, numeric_error_enable_bit, lirq_cfg_we, lirq_cfg_en;
  logic lock_seq, temp_max, thermal_ctrl_enable, deeper_sleep, pwr_ind_enable;
  logic [3:0] reset_vector_strap;
  logic snoop_done, snoop_stall_seen, fp_exception, int_reg_clear, built_in_selftest;
  logic maskable_irq, nmi, lock_seen, bus_yield, thermal_control_circuit;
  logic [3:0] restart_vector;
  logic [1:0] local_irq_out;
  int n_errors = 0;
  int total_checks = 0;
  int n_fpx, n_clr, n_selftest, nh, nm, nb;

  assign hready = hreadyout;
  always #12.5 ref_clk = ~ref_clk;

  sideband_if sb ();
  cpu_sideband_dev i_cpu_sideband_dev (.*, .rst_n(dev_rst_n));
  chipset_sideband_host i_chipset_sideband_host (.*);
  sideband_properties i_sideband_properties (
    .ref_clk(ref_clk),
    .rst_n(dev_rst_n),
    .dev_hit_o(sb.dev_hit_o),
    .dev_hit_oe_n(sb.dev_hit_oe_n),
    .dev_hitmod_o(sb.dev_hitmod_o),
    .dev_hitmod_oe_n(sb.dev_hitmod_oe_n),
    .dev_lock_o(sb.dev_lock_o),
    .dev_lock_oe_n(sb.dev_lock_oe_n),
    .dev_hot_o(sb.dev_hot_o),
    .dev_hot_oe_n(sb.dev_hot_oe_n),
    .internal_error_n(sb.internal_error_n),
    .shutdown_txn_n(sb.shutdown_txn_n)
  );

  // Pulses are counted mid-cycle, away from the launching edge
  always @(negedge ref_clk) begin
    n_fpx += int'(fp_exception === 1'b1);
    n_clr += int'(int_reg_clear === 1'b1);
    n_selftest += int'(built_in_selftest === 1'b1);
  end

  // ----------------------------------------
  // Bus and sequencing tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_errors++;
      complete_run();
    end
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    `CHK_EQ(hresp, 1'b0)
  endtask : ahb

  task automatic rd(input logic [31:0] a);
    ahb(1'b0, a, 32'h0, r);
  endtask : rd

  // Control pins reach the device through two sync flops, hence the settle time
  task automatic set_ctrl(input int b, input logic v);
    logic [31:0] q;
    ctrl[b] = v;
    ahb(1'b1, `SB_REG_CTRL, ctrl, q);
    tick(6);
  endtask : set_ctrl

  task automatic snoop(input logic h, m, input int stall);
    int n;
    n = 0;
    nh = 0;
    nm = 0;
    nb = 0;
    snoop_req <= 1'b1;
    snoop_hit <= h;
    snoop_hitmod <= m;
    snoop_stall_need <= (stall > 0);
    do begin
      @(posedge ref_clk);
      n++;
      snoop_req <= 1'b0;
      if (n >= stall) snoop_stall_need <= 1'b0;
      @(negedge ref_clk);
      if (!sb.snoop_hit_n && !sb.snoop_hit_modified_n) nb++;
      else if (!sb.snoop_hit_n) nh++;
      else if (!sb.snoop_hit_modified_n) nm++;
    end while (snoop_done !== 1'b1 && n < 40);
    `CHK_EQ(snoop_done, 1'b1)
    @(posedge ref_clk);
  endtask : snoop

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {snoop_req, snoop_hit, snoop_hitmod, snoop_stall_need, core_error, fp_insn} = '0;
    {fp_error_pending, numeric_error_enable_bit, lirq_cfg_we, lirq_cfg_en} = '0;
    {lock_seq, temp_max, thermal_ctrl_enable, deeper_sleep, pwr_ind_enable} = '0;
    {hsel, hwrite, htrans, haddr, hwdata, ctrl} = '0;
    {n_fpx, n_clr, n_selftest} = '0;
    reset_vector_strap = 4'ha;
    tick(8);
    rst_n <= 1'b1;
    dev_rst_n <= 1'b1;
    tick(6);
    `CHK_EQ(n_selftest, 0)
    rd(`SB_REG_CTRL);
    `CHK_EQ(r, 32'h0)
    set_ctrl(`SB_CTRL_MASK_IRQ, 1'b1);
    rd(32'h0000_0008);
    `CHK_EQ(r, 32'h0)
    `CHK_EQ(local_irq_out, 2'h1)
    `CHK_EQ(maskable_irq, 1'b0)
    lirq_cfg_we <= 1'b1;
    tick(1);
    lirq_cfg_we <= 1'b0;
    tick(4);
    `CHK_EQ(maskable_irq, 1'b1)
    set_ctrl(`SB_CTRL_NMI, 1'b1);
    `CHK_EQ(nmi, 1'b1)
    set_ctrl(`SB_CTRL_MASK_IRQ, 1'b0);
    set_ctrl(`SB_CTRL_NMI, 1'b0);
    `CHK_EQ({maskable_irq, nmi}, 2'h0)
    for (int i = 0; i < 4; i++) begin
      snoop(i[0], i[1], 0);
      `CHK_EQ({nh, nm, nb}, {int'(i == 1), int'(i >= 2), int'(0)})
    end
    snoop(1'b1, 1'b0, 3);
    `CHK_EQ(nb >= 2 && nh == 1, 1'b1)
    set_ctrl(`SB_CTRL_SNP_STALL, 1'b1);
    `CHK_EQ(snoop_stall_seen, 1'b1)
    set_ctrl(`SB_CTRL_SNP_STALL, 1'b0);
    set_ctrl(`SB_CTRL_SNP_HIT, 1'b1);
    rd(`SB_REG_STAT);
    `CHK_EQ(r[`SB_STAT_SNP_HIT], 1'b0)
    set_ctrl(`SB_CTRL_SNP_HIT, 1'b0);
    for (int i = 0; i < 8; i++) begin
      numeric_error_enable_bit <= i[0];
      fp_error_pending <= i[2];
      set_ctrl(`SB_CTRL_IGN, i[1]);
      n_fpx = 0;
      fp_insn <= 1'b1;
      tick(1);
      fp_insn <= 1'b0;
      tick(3);
      `CHK_EQ(n_fpx, int'(i[2] && (i[0] || !i[1])))
    end
    set_ctrl(`SB_CTRL_SHUT_NMI_EN, 1'b1);
    core_error <= 1'b1;
    tick(1);
    core_error <= 1'b0;
    // Pulse crosses two sync pairs plus the sticky and pin flops
    tick(8);
    `CHK_EQ(sb.internal_error_n, 1'b0)
    `CHK_EQ(nmi, 1'b1)
    rd(`SB_REG_STAT);
    `CHK_EQ({r[`SB_STAT_SHUT], r[`SB_STAT_INT_ERR]}, 2'h3)
    ahb(1'b1, `SB_REG_STAT, 32'h20, r);
    tick(6);
    rd(`SB_REG_STAT);
    `CHK_EQ(r[`SB_STAT_SHUT], 1'b0)
    `CHK_EQ({nmi, sb.internal_error_n}, 2'h0)
    lock_seq <= 1'b1;
    tick(2);
    `CHK_EQ(sb.lock_n, 1'b0)
    set_ctrl(`SB_CTRL_PRIO_REQ, 1'b1);
    rd(`SB_REG_STAT);
    `CHK_EQ({bus_yield, r[`SB_STAT_OWNED]}, 2'h0)
    `CHK_EQ(lock_seen, 1'b1)
    lock_seq <= 1'b0;
    tick(6);
    rd(`SB_REG_STAT);
    `CHK_EQ({bus_yield, r[`SB_STAT_OWNED], sb.lock_n}, 3'h7)
    `CHK_EQ(lock_seen, 1'b0)
    set_ctrl(`SB_CTRL_PRIO_REQ, 1'b0);
    thermal_ctrl_enable <= 1'b1;
    temp_max <= 1'b1;
    tick(4);
    `CHK_EQ({sb.thermal_hot_n, thermal_control_circuit}, 2'h1)
    temp_max <= 1'b0;
    set_ctrl(`SB_CTRL_HOT, 1'b1);
    `CHK_EQ(thermal_control_circuit, 1'b1)
    thermal_ctrl_enable <= 1'b0;
    tick(4);
    `CHK_EQ(thermal_control_circuit, 1'b0)
    thermal_ctrl_enable <= 1'b1;
    set_ctrl(`SB_CTRL_HOT, 1'b0);
    `CHK_EQ(thermal_control_circuit, 1'b0)
    deeper_sleep <= 1'b1;
    tick(4);
    `CHK_EQ(sb.power_status_ind_n, 1'b1)
    pwr_ind_enable <= 1'b1;
    tick(4);
    `CHK_EQ(sb.power_status_ind_n, 1'b0)
    n_clr = 0;
    set_ctrl(`SB_CTRL_INIT, 1'b1);
    snoop(1'b1, 1'b0, 0);
    `CHK_EQ(nh, 1)
    `CHK_EQ(n_clr, 1)
    `CHK_EQ(restart_vector, 4'ha)
    n_selftest = 0;
    dev_rst_n <= 1'b0;
    tick(3);
    `CHK_EQ(sb.internal_error_n, 1'b1)
    dev_rst_n <= 1'b1;
    tick(8);
    `CHK_EQ(n_selftest, 1)
    complete_run();
  end
endmodule : cpu_sideband_snoop_lock_ctrl_tb
